// ===== tb/nifb_chk.sv
/* Port checker for the frame builder: stream handshake, framing,
   checksum, indicator flash and identity request.
   Assumes it is bound to every builder instance. */
module nifb_chk (
    // Clock and reset
    input wire logic       CLK,
    input wire logic       RST_B,
    // Stream, side outputs and button input
    input wire logic       TX_VALID,
    input wire logic [7:0] TX_DATA,
    input wire logic       TX_LAST,
    input wire logic       TX_READY,
    input wire logic       ASSOC_LED,
    input wire logic       BUTTON_PRESS,
    input wire logic       IDENT_SEND
);
    logic [7:0]  idx_ff;
    logic [7:0]  sum_ff;
    logic [15:0] len_ff;
    wire         hs = TX_VALID && TX_READY;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_B);
    // Byte index within the frame
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) idx_ff <= 8'h00;
        else if (hs) idx_ff <= TX_LAST ? 8'h00 : idx_ff + 8'h01;
    end
    // Running sum from the type byte
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) sum_ff <= 8'h00;
        else if (hs && TX_LAST) sum_ff <= 8'h00;
        else if (hs && idx_ff >= 8'h03) sum_ff <= sum_ff + TX_DATA;
    end
    // Length field capture
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) len_ff <= 16'h0000;
        else if (hs && idx_ff == 8'h01) len_ff[15:8] <= TX_DATA;
        else if (hs && idx_ff == 8'h02) len_ff[7:0] <= TX_DATA;
    end
    hold_byte_a: assert property (TX_VALID && !TX_READY |=> TX_VALID
        && $stable(TX_DATA) && $stable(TX_LAST)) else $error("byte moved");
    idle_gap_a: assert property (hs |=> !TX_VALID)
        else $error("valid not dropped after handshake");
    start_byte_a: assert property (TX_VALID && idx_ff == 8'h00
        |-> TX_DATA == 8'h7E) else $error("bad start byte");
    type_code_a: assert property (TX_VALID && idx_ff == 8'h03
        |-> TX_DATA == 8'h95) else $error("bad type byte");
    opt_bits_a: assert property (TX_VALID && idx_ff == 8'h0E
        |-> (TX_DATA & 8'h35) == 8'h00 && TX_DATA[7:6] != 2'b00)
        else $error("bad options byte");
    sum_byte_a: assert property (TX_VALID && TX_LAST
        |-> TX_DATA == 8'hFF - sum_ff) else $error("bad checksum");
    len_count_a: assert property (TX_VALID && TX_LAST
        |-> {8'h00, idx_ff} == len_ff + 16'h0003)
        else $error("length field disagrees with frame");
    led_flash_a: assert property ($rose(TX_VALID) && idx_ff == 8'h00
        |-> ##[0:3] ASSOC_LED) else $error("indicator not flashed");
    ident_req_a: assert property ($rose(BUTTON_PRESS)
        |-> ##[1:4] IDENT_SEND) else $error("no identity request");
endmodule

bind nifb_frame_builder nifb_chk nifb_chk_inst (.CLK, .RST_B, .TX_VALID,
    .TX_DATA, .TX_LAST, .TX_READY, .ASSOC_LED, .BUTTON_PRESS, .IDENT_SEND);

// ===== tb/nifb_frame_builder_test.sv
/* Self-checking bench: random identification broadcasts, register
   access over Avalon-MM and identity triggers.
   Assumes the builder, its bound checker and the host sink model. */
module nifb_frame_builder_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LMAX = 8;
    logic            clk, rst_b, rx_valid, bcast, button, awake, slow;
    logic [63:0]     src, rem;
    logic [1:0]      method, role;
    logic [7:0]      evt, rssi, lab_len, tx_data;
    logic [31:0]     devtype, avs_wdata, avs_rdata, q;
    logic [LMAX*8-1:0] label;
    logic            rx_ready, ident, tx_valid, tx_last, tx_ready, led;
    logic [3:0]      avs_addr;
    logic            avs_rd, avs_wr, avs_wait, led_seen;
    logic [7:0]      got[$], exp_q[$];
    int              error_cnt, cmp_count, good_cnt, cyc, ident_cnt, last_at, n;

    nifb_frame_builder #(.LABEL_MAX(LMAX), .FLASH_CYCLES(10),
        .AWAKE_CYCLES(50)) nifb_frame_builder_inst (.CLK(clk),
        .RST_B(rst_b), .RX_VALID(rx_valid), .RX_SRC_ADDR(src),
        .RX_REM_ADDR(rem), .RX_BCAST(bcast), .RX_METHOD(method),
        .RX_ROLE(role), .RX_EVENT(evt), .RX_DEVTYPE(devtype),
        .RX_RSSI(rssi), .RX_LABEL_LEN(lab_len), .RX_LABEL(label),
        .RX_READY(rx_ready), .BUTTON_PRESS(button), .SYNC_AWAKE(awake),
        .IDENT_SEND(ident), .TX_VALID(tx_valid), .TX_DATA(tx_data),
        .TX_LAST(tx_last), .TX_READY(tx_ready), .ASSOC_LED(led),
        .AVS_ADDRESS(avs_addr), .AVS_READ(avs_rd), .AVS_WRITE(avs_wr),
        .AVS_WRITEDATA(avs_wdata), .AVS_READDATA(avs_rdata),
        .AVS_WAITREQUEST(avs_wait));
    nifb_host_sink nifb_host_sink_inst (.clk(clk), .rst_b(rst_b),
        .slow(slow), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_last(tx_last), .tx_ready(tx_ready), .good_cnt(good_cnt));

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic check(string what, logic [31:0] seen, logic [31:0] want);
        cmp_count++;
        if (seen !== want) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic bus(logic wr, logic [3:0] a, logic [31:0] d);
        @(posedge clk);
        avs_addr <= a;
        avs_wdata <= d;
        avs_rd <= !wr;
        avs_wr <= wr;
        do @(posedge clk); while (avs_wait !== 1'b0);
        q = avs_rdata;
        avs_rd <= 1'b0;
        avs_wr <= 1'b0;
    endtask
    function automatic void put(logic [7:0] b);
        exp_q.push_back(b);
    endfunction
    // Expected frame from the captured broadcast fields
    function automatic void build(logic dv, logic rs);
        logic [7:0] s = 8'h00;
        int len;
        exp_q = {};
        put(8'h95);
        for (int i = 7; i >= 0; i--) put(src[8*i+:8]);
        put(8'hFF); put(8'hFE);
        put({method, 4'h0, bcast, 1'b0});
        put(8'hFF); put(8'hFE);
        for (int i = 7; i >= 0; i--) put(rem[8*i+:8]);
        for (int i = 0; i < lab_len; i++) put(label[8*i+:8]);
        put(8'h00); put(8'hFF); put(8'hFE);
        put({6'h00, role}); put(evt);
        put(nifb_pkg::PROFILE_CODE[15:8]); put(nifb_pkg::PROFILE_CODE[7:0]);
        put(nifb_pkg::MAKER_CODE[15:8]); put(nifb_pkg::MAKER_CODE[7:0]);
        if (dv) for (int i = 3; i >= 0; i--) put(devtype[8*i+:8]);
        if (rs) put(rssi);
        foreach (exp_q[i]) s += exp_q[i];
        len = exp_q.size();
        exp_q.push_front(8'(len));
        exp_q.push_front(8'(len >> 8));
        exp_q.push_front(8'h7E);
        put(8'hFF - s);
    endfunction
    task automatic frame(int k);
        logic [LMAX*8-1:0] lb;
        bus(1'b1, 4'h0, {30'h0, k[1:0]});
        @(posedge clk);
        src <= {$urandom, $urandom};
        rem <= {$urandom, $urandom};
        bcast <= $urandom;
        method <= 2'(k % 3 + 1);
        role <= 2'(k % 3);
        evt <= (k == 3) ? 8'h01 : 8'($urandom);
        devtype <= $urandom;
        rssi <= $urandom;
        lab_len <= (k == 7) ? 8'(LMAX) : (k == 0) ? 8'h01 : 8'(1 + $urandom % LMAX);
        for (int i = 0; i < LMAX; i++) lb[8*i+:8] = 8'(8'h41 + $urandom % 26);
        label <= lb;
        slow <= k[2];
        rx_valid <= 1'b1;
        got = {};
        led_seen = 1'b0;
        last_at = -1;
        for (n = 0; got.size() == 0 && n < 200; n++) @(posedge clk);
        rx_valid <= 1'b0;
        check("ready busy", rx_ready, 1'b0);
        for (n = 0; last_at < 0 && n < 2000; n++) @(posedge clk);
        build(k[0], k[1]);
        check("frame size", got.size(), exp_q.size());
        foreach (exp_q[i]) check("frame byte", got[i], exp_q[i]);
        check("last byte", last_at, exp_q.size() - 1);
        check("indicator", led_seen, 1'b1);
        repeat (2) @(posedge clk);
        check("ready idle", rx_ready, 1'b1);
    endtask

    always @(posedge clk) begin
        if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
            got.push_back(tx_data);
            if (tx_last === 1'b1) last_at = got.size() - 1;
        end
        if (led === 1'b1) led_seen = 1'b1;
        if (ident === 1'b1) ident_cnt++;
        cyc++;
        if (cyc == 40000) begin
            error_cnt++;
            print_verdict();
        end
    end
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        void'($urandom(32'h7079));
        {rst_b, rx_valid, bcast, button, awake, slow, avs_rd, avs_wr} = '0;
        {src, rem, method, role, evt, rssi, lab_len, devtype} = '0;
        {label, avs_addr, avs_wdata} = '0;
        repeat (8) @(posedge clk);
        check("reset valid", tx_valid, 1'b0);
        check("reset wait", avs_wait, 1'b1);
        rst_b <= 1'b1;
        for (int k = 0; k < 8; k++) frame(k);
        bus(1'b0, 4'h1, 32'h0);
        check("frames sent", q[15:0], 16'h0008);
        check("host accepted", good_cnt, 8);
        bus(1'b1, 4'hF, 32'hFFFFFFFF);
        bus(1'b0, 4'hF, 32'h0);
        check("unmapped read", q, 32'h0);
        bus(1'b0, 4'h0, 32'h0);
        check("ctrl readback", q[1:0], 2'h3);
        n = ident_cnt;
        bus(1'b1, 4'h2, 32'h1);
        repeat (4) @(posedge clk);
        button <= 1'b1;
        repeat (6) @(posedge clk);
        button <= 1'b0;
        awake <= 1'b1;
        repeat (40) @(posedge clk);
        awake <= 1'b0;
        repeat (4) @(posedge clk);
        check("cmd and button", ident_cnt - n, 2);
        awake <= 1'b1;
        repeat (60) @(posedge clk);
        awake <= 1'b0;
        repeat (4) @(posedge clk);
        check("awake timeout", ident_cnt - n, 3);
        print_verdict();
    end
endmodule

// ===== tb/nifb_host_sink.sv
/* Host model: byte sink with prompt or stalling ready; counts frames
   whose checksum holds. Assumes the builder's valid/ready stream. */
module nifb_host_sink (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_b,
    // Stream
    input  wire logic       slow,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_last,
    output logic            tx_ready,
    // Result
    output int              good_cnt
);
    logic [7:0] sum_ff;
    int         idx_ff;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) tx_ready <= 1'b0;
        else tx_ready <= !slow || ($urandom % 3 == 0);
    end
    // Frame check, bad frames dropped
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sum_ff <= 8'h00;
            idx_ff <= 0;
            good_cnt <= 0;
        end else if (tx_valid && tx_ready) begin
            idx_ff <= tx_last ? 0 : idx_ff + 1;
            sum_ff <= (tx_last || idx_ff < 3) ? 8'h00 : sum_ff + tx_data;
            if (tx_last && sum_ff + tx_data == 8'hFF) good_cnt <= good_cnt + 1;
        end
    end
endmodule

// ===== verilog/nifb_frame_builder.sv
/*
 * Node identification frame builder: on a received identification
 * broadcast it streams the indicator frame out, one byte per handshake,
 * and flashes the association indicator. It also raises the request to
 * send this node's own identity broadcast. Registers on Avalon-MM.
 * Assumes a byte sink with valid/ready and an Avalon-MM master that
 * holds its request until waitrequest is low.
 */
// Our own choices: the address map and the Avalon-MM slave port.
// Behaviour
// R1: Frame opens with start byte then 16-bit length of bytes before checksum.
// R2: Received identity broadcast yields a frame with the indicator type byte.
// R3: Offset four carries the eight-byte address of the sending node.
// R4: Reserved two-byte fields are filled with FFFE.
// R5: Options bit 1 marks a broadcast; bits 0, 2, 4, 5 stay zero.
// R6: Options bits 7:6 hold the delivery method, 01, 10 or 11.
// R7: Option bits are ORed together into one byte.
// R8: Offset 17 carries the eight-byte address of the originating node.
// R9: Label string from offset 25, ended by a zero byte.
// R10: Network role byte follows the reserved field after the label.
// R11: Cause byte follows the role byte; one means pushbutton.
// R12: Profile code then manufacturer code, fixed, two bytes each.
// R13: Four-byte device type included only when its option bit is set.
// R14: Signal strength byte before checksum only when its option bit is set.
// R15: Checksum is FF minus low byte of sum from type byte onward.
// R16: Own identity sent on button press, command 1, or 30 s awake.
// R17: Every received broadcast flashes the indicator and emits a frame.
// R18: Multi-byte fields go most significant byte first; start byte 7E.
// R19: Host discards bad checksums and finds optional fields by length.
module nifb_frame_builder #(
    parameter int LABEL_MAX = 32,
    parameter int FLASH_CYCLES = nifb_pkg::FLASH_CYC,
    parameter logic [31:0] AWAKE_CYCLES = nifb_pkg::AWAKE_CYC
) (
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        RST_B,
    // Received identification broadcast
    input  wire logic        RX_VALID,
    input  wire logic [63:0] RX_SRC_ADDR,
    input  wire logic [63:0] RX_REM_ADDR,
    input  wire logic        RX_BCAST,
    input  wire logic [1:0]  RX_METHOD,
    input  wire logic [1:0]  RX_ROLE,
    input  wire logic [7:0]  RX_EVENT,
    input  wire logic [31:0] RX_DEVTYPE,
    input  wire logic [7:0]  RX_RSSI,
    input  wire logic [7:0]  RX_LABEL_LEN,
    input  wire logic [LABEL_MAX*8-1:0] RX_LABEL,
    output logic             RX_READY,
    // Own identity triggers
    input  wire logic        BUTTON_PRESS,
    input  wire logic        SYNC_AWAKE,
    output logic             IDENT_SEND,
    // Serial byte stream to host
    output logic             TX_VALID,
    output logic [7:0]       TX_DATA,
    output logic             TX_LAST,
    input  wire logic        TX_READY,
    // Association indicator
    output logic             ASSOC_LED,
    // Avalon-MM slave
    input  wire logic [3:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    output logic [31:0]      AVS_READDATA,
    output logic             AVS_WAITREQUEST
);
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h1;
    localparam logic [3:0] REG_CMD    = 4'h2;

    nifb_pkg::nifb_state_t state_ff;
    logic [63:0] src_ff;
    logic [63:0] rem_ff;
    logic [7:0]  opt_ff;
    logic [7:0]  role_ff;
    logic [7:0]  event_ff;
    logic [31:0] devt_ff;
    logic [7:0]  rssi_ff;
    logic [7:0]  llen_ff;
    logic [LABEL_MAX*8-1:0] label_ff;
    logic [7:0]  idx_ff;
    logic [7:0]  sum_ff;
    logic [1:0]  ctrl_ff;
    logic [15:0] frames_ff;
    logic [31:0] flash_ff;
    logic [31:0] awake_ff;
    logic        ack_ff;
    logic        button_ff;
    logic [15:0] len;
    logic [7:0]  head_byte;
    logic [7:0]  trl_byte;
    logic [7:0]  cur_byte;
    logic        adv;
    logic        bus_req;

    assign adv = TX_VALID && TX_READY;
    assign bus_req = (AVS_READ || AVS_WRITE) && !ack_ff;

    // Length covers type byte to before checksum [R1] [R13] [R14]
    always_comb begin
        len = nifb_pkg::BASE_LEN + {8'h00, llen_ff};
        if (ctrl_ff[0]) begin
            len = len + nifb_pkg::DEVTYPE_LEN;
        end
        if (ctrl_ff[1]) begin
            len = len + nifb_pkg::RSSI_LEN;
        end
    end

    // Header bytes up to the label, MSB first [R18]
    always_comb begin
        head_byte = 8'h00;
        case (idx_ff[5:0])
            6'h00: head_byte = nifb_pkg::START_BYTE;            // [R1]
            6'h01: head_byte = len[15:8];                       // [R1]
            6'h02: head_byte = len[7:0];
            6'h03: head_byte = nifb_pkg::TYPE_NODE_ID;          // [R2]
            nifb_pkg::OFS_OPT: head_byte = opt_ff;               // [R5]
            default: begin
                if (idx_ff[5:0] >= nifb_pkg::OFS_REM) begin     // [R8]
                    head_byte = rem_ff[8'(8'h07 - 8'(idx_ff[5:0]
                                - nifb_pkg::OFS_REM)) * 8 +: 8];
                end else if (idx_ff[5:0] >= nifb_pkg::OFS_RES1) begin
                    head_byte = (idx_ff[5:0] == nifb_pkg::OFS_RES1) ?
                        nifb_pkg::RESERVED_FILL[15:8] :
                        nifb_pkg::RESERVED_FILL[7:0];           // [R4]
                end else if (idx_ff[5:0] >= nifb_pkg::OFS_RES0) begin
                    head_byte = (idx_ff[5:0] == nifb_pkg::OFS_RES0) ?
                        nifb_pkg::RESERVED_FILL[15:8] :
                        nifb_pkg::RESERVED_FILL[7:0];           // [R4]
                end else begin                                  // [R3]
                    head_byte = src_ff[8'(8'h07 - 8'(idx_ff[5:0]
                                - nifb_pkg::OFS_SRC)) * 8 +: 8];
                end
            end
        endcase
    end

    // Trailer after the label terminator
    always_comb begin
        trl_byte = 8'h00;
        case (idx_ff[3:0])
            nifb_pkg::TRL_RES:   trl_byte = nifb_pkg::RESERVED_FILL[15:8];
            4'h1:                trl_byte = nifb_pkg::RESERVED_FILL[7:0];
            nifb_pkg::TRL_ROLE:  trl_byte = role_ff;              // [R10]
            nifb_pkg::TRL_EVENT: trl_byte = event_ff;             // [R11]
            nifb_pkg::TRL_PROF:  trl_byte = nifb_pkg::PROFILE_CODE[15:8];
            4'h5:                trl_byte = nifb_pkg::PROFILE_CODE[7:0];
            nifb_pkg::TRL_MFG:   trl_byte = nifb_pkg::MAKER_CODE[15:8];
            4'h7:                trl_byte = nifb_pkg::MAKER_CODE[7:0]; // [R12]
            default:             trl_byte = 8'h00;
        endcase
    end

    always_comb begin
        cur_byte = 8'h00;
        case (state_ff)
            nifb_pkg::ST_HEAD:  cur_byte = head_byte;
            nifb_pkg::ST_LABEL: cur_byte = (idx_ff < llen_ff) ?
                                label_ff[idx_ff*8 +: 8] :
                                nifb_pkg::LABEL_END;             // [R9]
            nifb_pkg::ST_TRAIL: cur_byte = trl_byte;
            nifb_pkg::ST_DEVT:  cur_byte = devt_ff[8'(8'h03 - idx_ff)*8 +: 8];
            nifb_pkg::ST_RSSI:  cur_byte = rssi_ff;              // [R14]
            nifb_pkg::ST_SUM:   cur_byte = 8'hFF - sum_ff;       // [R15]
            default:            cur_byte = 8'h00;
        endcase
    end

    // Frame sequencer [R17]
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            state_ff <= nifb_pkg::ST_IDLE;
            idx_ff   <= 8'h00;
        end else begin
            case (state_ff)
                nifb_pkg::ST_IDLE: begin
                    if (RX_VALID) begin                          // [R2]
                        state_ff <= nifb_pkg::ST_HEAD;
                        idx_ff   <= 8'h00;
                    end
                end
                nifb_pkg::ST_HEAD: if (adv) begin
                    if (idx_ff[5:0] == nifb_pkg::OFS_LABEL - 6'h01) begin
                        state_ff <= nifb_pkg::ST_LABEL;
                        idx_ff   <= 8'h00;
                    end else begin
                        idx_ff <= idx_ff + 8'h01;
                    end
                end
                nifb_pkg::ST_LABEL: if (adv) begin
                    if (idx_ff >= llen_ff) begin                 // [R9]
                        state_ff <= nifb_pkg::ST_TRAIL;
                        idx_ff   <= 8'h00;
                    end else begin
                        idx_ff <= idx_ff + 8'h01;
                    end
                end
                nifb_pkg::ST_TRAIL: if (adv) begin
                    if (idx_ff[3:0] == nifb_pkg::TRL_END - 4'h1) begin
                        idx_ff <= 8'h00;
                        if (ctrl_ff[0]) begin                    // [R13]
                            state_ff <= nifb_pkg::ST_DEVT;
                        end else if (ctrl_ff[1]) begin           // [R14]
                            state_ff <= nifb_pkg::ST_RSSI;
                        end else begin
                            state_ff <= nifb_pkg::ST_SUM;
                        end
                    end else begin
                        idx_ff <= idx_ff + 8'h01;
                    end
                end
                nifb_pkg::ST_DEVT: if (adv) begin
                    if (idx_ff[3:0] == nifb_pkg::TRL_DEVTYPE_N - 4'h1) begin
                        state_ff <= ctrl_ff[1] ? nifb_pkg::ST_RSSI :
                                    nifb_pkg::ST_SUM;
                    end else begin
                        idx_ff <= idx_ff + 8'h01;
                    end
                end
                nifb_pkg::ST_RSSI: if (adv) begin
                    state_ff <= nifb_pkg::ST_SUM;
                end
                nifb_pkg::ST_SUM: if (adv) begin
                    state_ff <= nifb_pkg::ST_IDLE;
                end
                default: state_ff <= nifb_pkg::ST_IDLE;
            endcase
        end
    end

    // Capture of the received broadcast fields
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            src_ff   <= 64'h0;
            rem_ff   <= 64'h0;
            opt_ff   <= 8'h00;
            role_ff  <= 8'h00;
            event_ff <= 8'h00;
            devt_ff  <= 32'h0;
            rssi_ff  <= 8'h00;
            llen_ff  <= 8'h00;
            label_ff <= '0;
        end else if (state_ff == nifb_pkg::ST_IDLE && RX_VALID) begin
            src_ff   <= RX_SRC_ADDR;
            rem_ff   <= RX_REM_ADDR;
            // Method and broadcast bits ORed, reserved bits zero [R6] [R7]
            opt_ff   <= (({RX_METHOD, 6'h00} & nifb_pkg::OPT_METHOD_MSK)
                        | (RX_BCAST ? nifb_pkg::OPT_BCAST : 8'h00))
                        & nifb_pkg::OPT_KEEP_MSK;
            role_ff  <= {6'h00, RX_ROLE};
            event_ff <= RX_EVENT;
            devt_ff  <= RX_DEVTYPE;
            rssi_ff  <= RX_RSSI;
            llen_ff  <= (RX_LABEL_LEN > 8'(LABEL_MAX)) ? 8'(LABEL_MAX) :
                        RX_LABEL_LEN;
            label_ff <= RX_LABEL;
        end
    end

    // Stream outputs and running checksum [R15]
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            TX_VALID <= 1'b0;
            TX_DATA  <= 8'h00;
            TX_LAST  <= 1'b0;
            sum_ff   <= 8'h00;
            RX_READY <= 1'b0;
        end else begin
            RX_READY <= (state_ff == nifb_pkg::ST_IDLE) && !RX_VALID;
            TX_VALID <= 1'b0;
            if (state_ff != nifb_pkg::ST_IDLE && !adv) begin
                TX_VALID <= 1'b1;
                TX_DATA  <= cur_byte;
                TX_LAST  <= (state_ff == nifb_pkg::ST_SUM);
            end
            if (state_ff == nifb_pkg::ST_IDLE) begin
                sum_ff <= 8'h00;
            end else if (adv && !(state_ff == nifb_pkg::ST_HEAD
                         && idx_ff < 8'h03)) begin
                sum_ff <= sum_ff + TX_DATA;
            end
        end
    end

    // Indicator flash and own identity triggers [R16] [R17]
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            flash_ff   <= 32'h0;
            ASSOC_LED  <= 1'b0;
            awake_ff   <= 32'h0;
            IDENT_SEND <= 1'b0;
            button_ff  <= 1'b0;
        end else begin
            if (state_ff == nifb_pkg::ST_IDLE && RX_VALID) begin
                flash_ff <= 32'(FLASH_CYCLES);
            end else if (flash_ff != 32'h0) begin
                flash_ff <= flash_ff - 32'h1;
            end
            ASSOC_LED <= (flash_ff != 32'h0);
            awake_ff  <= SYNC_AWAKE ? awake_ff + 32'h1 : 32'h0;
            button_ff  <= BUTTON_PRESS;
            // One request per press, not per cycle held
            IDENT_SEND <= (BUTTON_PRESS && !button_ff)
                || (AVS_WRITE && ack_ff && AVS_ADDRESS == REG_CMD
                    && AVS_WRITEDATA[7:0] == 8'h01)
                || (SYNC_AWAKE && awake_ff == 32'(AWAKE_CYCLES) - 32'h1);
        end
    end

    // Avalon-MM slave, one wait cycle per access
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            ack_ff          <= 1'b0;
            AVS_WAITREQUEST <= 1'b1;
            AVS_READDATA    <= 32'h0;
            ctrl_ff         <= 2'b00;
            frames_ff       <= 16'h0;
        end else begin
            ack_ff          <= bus_req;
            AVS_WAITREQUEST <= !bus_req;
            if (state_ff == nifb_pkg::ST_SUM && adv) begin
                frames_ff <= frames_ff + 16'h1;
            end
            if (ack_ff && AVS_WRITE && AVS_ADDRESS == REG_CTRL) begin
                ctrl_ff <= AVS_WRITEDATA[1:0];
            end
            if (bus_req && AVS_READ) begin
                case (AVS_ADDRESS)
                    REG_CTRL:   AVS_READDATA <= {30'h0, ctrl_ff};
                    REG_STATUS: AVS_READDATA <= {9'h0, state_ff, frames_ff};
                    default:    AVS_READDATA <= 32'h0;
                endcase
            end
        end
    end
endmodule

// ===== verilog/nifb_pkg.sv
/*
 * Constants for the node identification frame builder: frame codes,
 * field values, option bits and byte offsets.
 * Assumes nothing of its surroundings.
 */
package nifb_pkg;
    localparam logic [7:0]  START_BYTE     = 8'h7E;
    localparam logic [7:0]  TYPE_NODE_ID   = 8'h95;
    localparam logic [15:0] RESERVED_FILL  = 16'hFFFE;
    localparam logic [7:0]  OPT_BCAST      = 8'h02;
    localparam logic [7:0]  OPT_METHOD_MSK = 8'hC0;
    localparam logic [7:0]  OPT_KEEP_MSK   = 8'hC2;
    localparam logic [7:0]  LABEL_END      = 8'h00;
    // Fixed header length counted from the type byte through the
    // manufacturer code, terminator included, without the label characters
    localparam logic [15:0] BASE_LEN       = 16'h001F;
    localparam logic [15:0] DEVTYPE_LEN    = 16'h0004;
    localparam logic [15:0] RSSI_LEN       = 16'h0001;
    // Byte offsets of fields before the label
    localparam logic [5:0]  OFS_SRC        = 6'h04;
    localparam logic [5:0]  OFS_RES0       = 6'h0C;
    localparam logic [5:0]  OFS_OPT        = 6'h0E;
    localparam logic [5:0]  OFS_RES1       = 6'h0F;
    localparam logic [5:0]  OFS_REM        = 6'h11;
    localparam logic [5:0]  OFS_LABEL      = 6'h19;
    // Trailer byte positions after the label terminator
    localparam logic [3:0]  TRL_RES        = 4'h0;
    localparam logic [3:0]  TRL_ROLE       = 4'h2;
    localparam logic [3:0]  TRL_EVENT      = 4'h3;
    localparam logic [3:0]  TRL_PROF       = 4'h4;
    localparam logic [3:0]  TRL_MFG        = 4'h6;
    localparam logic [3:0]  TRL_END        = 4'h8;
    localparam logic [3:0]  TRL_DEVTYPE_N  = 4'h4;
    // Flash length of the association indicator, in microseconds
    localparam int          FLASH_US       = 100;
    localparam int          CLK_MHZ        = 125;
    localparam int          FLASH_CYC      = FLASH_US * CLK_MHZ;
    localparam int          AWAKE_S        = 30;
    localparam logic [31:0] AWAKE_CYC      = 32'(64'(AWAKE_S) * 64'(CLK_MHZ)
                                             * 64'h0F4240);
    // Arbitrary neutral identification values
    localparam logic [15:0] PROFILE_CODE   = 16'h1111;
    localparam logic [15:0] MAKER_CODE     = 16'h2222;
    typedef enum logic [6:0] {
        ST_IDLE  = 7'h01,
        ST_HEAD  = 7'h02,
        ST_LABEL = 7'h04,
        ST_TRAIL = 7'h08,
        ST_DEVT  = 7'h10,
        ST_RSSI  = 7'h20,
        ST_SUM   = 7'h40
    } nifb_state_t;
endpackage
